// *** hw/fwu_pkg.sv ***
// constants and types of the firmware upload command block
package fwu_pkg;
   // -------------------------------------------------------------
   // command codes
   // -------------------------------------------------------------
   localparam logic [7:0] CMD_HW_COMPAT = 8'hd4;
   localparam logic [7:0] CMD_CAPABILITY = 8'hd5;
   localparam logic [7:0] CMD_MODE = 8'hd6;
   localparam logic [7:0] CMD_BLOCK = 8'hd7;
   localparam logic [7:0] CMD_STATUS = 8'hd8;
   localparam logic [7:0] CMD_FW_REV = 8'hd9;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int MODE_UPLOAD_BIT = 0;
   localparam int CAP_STANDBY_BIT = 0;
   localparam int CAP_ON_CYCLE_BIT = 1;
   localparam int CAP_ON_NOCYCLE_BIT = 2;
   localparam int ST_OK_BIT = 0;
   localparam int ST_WAIT_BIT = 1;
   localparam int ST_BAD_SAFE_BIT = 2;
   localparam int ST_BAD_FULL_BIT = 3;
   localparam int ST_UNSUP_BIT = 4;
   // -------------------------------------------------------------
   // image header byte indices (payload of block 0)
   // -------------------------------------------------------------
   localparam int HDR_CRC_LO = 0;
   localparam int HDR_CRC_HI = 1;
   localparam int HDR_MAJOR = 23;
   localparam int HDR_MINOR_PRI = 24;
   localparam int HDR_MINOR_SEC = 25;
   localparam int HDR_COMPAT_1 = 26;
   localparam int HDR_COMPAT_2 = 27;
   localparam int HDR_BSIZE_LO = 28;
   localparam int HDR_BSIZE_HI = 29;
   localparam logic [15:0] HDR_LEN = 16'h0020;
   localparam logic [7:0] SEQ_HEADER = 8'h00;
   // -------------------------------------------------------------
   // reset values and timing
   // -------------------------------------------------------------
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] BSIZE_RST = 16'h0000;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam int CLK_HZ = 20000000;
   localparam int LED_HALF_MS = 250;
   localparam int LED_HALF_CYC = CLK_HZ / 1000 * LED_HALF_MS;
   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic {PS_SEQ, PS_PAY} fwu_parse_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } fwu_mem_word_t;
   typedef struct packed {
      logic [23:0] data;
      logic [1:0] len;
   } fwu_rsp_t;
endpackage : fwu_pkg

// *** hw/fwu_upload_ctrl.sv ***
// firmware upload command interpreter with program memory write path
`timescale 1ns/10ps
module fwu_upload_ctrl #(
   parameter logic [7:0] HW_COMPAT_FIRST = 8'h41,  // arbitrary value
   parameter logic [7:0] HW_COMPAT_SECOND = 8'h30, // arbitrary value
   parameter logic [23:0] FW_REV_INIT = 24'h010000,
   parameter logic CAP_STANDBY_ONLY = 1'b0,
   parameter logic CAP_ON_CYCLE = 1'b0,
   parameter logic CAP_ON_NOCYCLE = 1'b1,
   parameter logic CORRUPT_FULL_FEATURE = 1'b0,
   parameter logic [15:0] IMG_BLOCKS = 16'h0004,
   parameter int LED_HALF_CYC = fwu_pkg::LED_HALF_CYC
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [7:0] req_code_i,
   input wire logic [7:0] req_wdata_i,
   input wire logic blk_valid_i,
   input wire logic [7:0] blk_byte_i,
   input wire logic blk_last_i,
   output logic blk_ready_o,
   output logic rsp_valid_o,
   output fwu_pkg::fwu_rsp_t rsp_o,
   output logic mem_valid_o,
   output fwu_pkg::fwu_mem_word_t mem_word_o,
   input wire logic mem_ready_i,
   output logic upload_mode_o,
   output logic standby_req_o,
   output logic safe_mode_o,
   output logic led_green_o
);
   // -------------------------------------------------------------
   // functions
   // -------------------------------------------------------------
   function automatic logic [15:0] blk_addr(input logic [7:0] seq, input logic [15:0] bsize,
                                            input logic [15:0] off);
      logic [31:0] full;
      full = 32'((seq - 8'h01) * bsize) + 32'(off);
      blk_addr = full[15:0];
   endfunction : blk_addr

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic upload_r, corrupt_r, refused_r, hdr_ok_r, done_r, len_err_r;
   logic st_ok_r, st_wait_r, st_bad_r, st_unsup_r;
   fwu_pkg::fwu_parse_t pstate_r;
   logic [7:0] seq_r;
   logic [15:0] pay_cnt_r, bsize_r, sum_r, blocks_r;
   logic [7:0] hdr_r [0:31];
   logic [23:0] fw_rev_r;
   logic ready_r, rsp_valid_r, mem_valid_r, standby_r, led_r;
   fwu_pkg::fwu_rsp_t rsp_r;
   fwu_pkg::fwu_mem_word_t ent_r [0:1];
   logic [1:0] cnt_r;
   logic [31:0] led_cnt_r;

   // -------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------
   wire mode_wr = req_valid_i & req_write_i & (req_code_i == fwu_pkg::CMD_MODE);
   wire enter = mode_wr & req_wdata_i[fwu_pkg::MODE_UPLOAD_BIT];
   wire leave = mode_wr & ~req_wdata_i[fwu_pkg::MODE_UPLOAD_BIT] & ~corrupt_r;
   wire rd_req = req_valid_i & ~req_write_i;
   wire blk_take = blk_valid_i & ready_r;
   wire accept = upload_r & ~refused_r & ~enter;
   wire in_pay = blk_take & (pstate_r == fwu_pkg::PS_PAY);
   wire is_hdr = (seq_r == fwu_pkg::SEQ_HEADER);
   wire blk_end = in_pay & blk_last_i;
   wire [15:0] pay_len = pay_cnt_r + 16'h0001;
   wire push = in_pay & accept & ~is_hdr & hdr_ok_r;
   wire [15:0] sum_nxt = push ? sum_r + {8'h00, blk_byte_i} : sum_r;
   wire hdr_end = blk_end & accept & is_hdr & (pay_len == fwu_pkg::HDR_LEN);
   wire compat_bad = (hdr_r[fwu_pkg::HDR_COMPAT_1] != HW_COMPAT_FIRST) |
                     (hdr_r[fwu_pkg::HDR_COMPAT_2] != HW_COMPAT_SECOND);
   wire data_end = blk_end & accept & ~is_hdr & hdr_ok_r;
   wire len_bad = data_end & (pay_len != bsize_r);
   wire img_done = data_end & (blocks_r + 16'h0001 == IMG_BLOCKS) & ~done_r;
   wire img_good = (sum_nxt == {hdr_r[fwu_pkg::HDR_CRC_HI], hdr_r[fwu_pkg::HDR_CRC_LO]}) &
                   ~len_err_r & ~len_bad;
   wire [15:0] status_w = {11'h000, st_unsup_r, st_bad_r & CORRUPT_FULL_FEATURE,
                           st_bad_r & ~CORRUPT_FULL_FEATURE, st_wait_r, st_ok_r};
   // every image lives in the main program space, so any advertised mode covers it all
   wire [7:0] cap_w = {5'h00, CAP_ON_NOCYCLE, CAP_ON_CYCLE, CAP_STANDBY_ONLY};
   wire [23:0] rd_data =
      (req_code_i == fwu_pkg::CMD_HW_COMPAT) ? {8'h00, HW_COMPAT_SECOND, HW_COMPAT_FIRST} :
      (req_code_i == fwu_pkg::CMD_CAPABILITY) ? {16'h0000, cap_w} :
      (req_code_i == fwu_pkg::CMD_MODE) ? {16'h0000, 7'h00, upload_r} :
      (req_code_i == fwu_pkg::CMD_STATUS) ? {8'h00, status_w} :
      (req_code_i == fwu_pkg::CMD_FW_REV) ? fw_rev_r : 24'h000000;
   wire [1:0] rd_len =
      (req_code_i == fwu_pkg::CMD_HW_COMPAT) ? 2'h2 :
      (req_code_i == fwu_pkg::CMD_CAPABILITY) ? 2'h1 :
      (req_code_i == fwu_pkg::CMD_MODE) ? 2'h1 :
      (req_code_i == fwu_pkg::CMD_STATUS) ? 2'h2 :
      (req_code_i == fwu_pkg::CMD_FW_REV) ? 2'h3 : 2'h0;
   wire pop = (cnt_r != 2'h0) & mem_ready_i;
   wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   wire fwu_pkg::fwu_mem_word_t new_word = '{addr: blk_addr(seq_r, bsize_r, pay_cnt_r),
                                              data: blk_byte_i};

   // -------------------------------------------------------------
   // upload mode and status
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         upload_r <= 1'b0;
         corrupt_r <= 1'b0;
         refused_r <= 1'b0;
         done_r <= 1'b0;
         st_ok_r <= 1'b0;
         st_wait_r <= 1'b0;
         st_bad_r <= 1'b0;
         st_unsup_r <= 1'b0;
         fw_rev_r <= FW_REV_INIT;
      end
      else if (clk_en_i)
      begin
         if (enter)
         begin
            upload_r <= 1'b1;
            refused_r <= 1'b0;
            done_r <= 1'b0;
            {st_ok_r, st_wait_r, st_bad_r, st_unsup_r} <= 4'h0;
         end
         else
         begin
            // a corrupt verdict in the cycle of an exit request still holds the mode
            if (leave && !(img_done && !img_good))
               upload_r <= 1'b0;
            st_wait_r <= upload_r & ~done_r & ~refused_r & ~img_done;
            if (hdr_end & compat_bad)
            begin
               refused_r <= 1'b1;
               st_unsup_r <= 1'b1;
            end
            if (img_done)
            begin
               done_r <= 1'b1;
               st_ok_r <= img_good;
               st_bad_r <= ~img_good;
               corrupt_r <= ~img_good;
               if (img_good)
                  fw_rev_r <= {hdr_r[fwu_pkg::HDR_MAJOR], hdr_r[fwu_pkg::HDR_MINOR_PRI],
                               hdr_r[fwu_pkg::HDR_MINOR_SEC]};
            end
         end
      end
   end

   // -------------------------------------------------------------
   // block parser
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pstate_r <= fwu_pkg::PS_SEQ;
         seq_r <= 8'h00;
         pay_cnt_r <= 16'h0000;
         hdr_ok_r <= 1'b0;
         bsize_r <= fwu_pkg::BSIZE_RST;
         sum_r <= 16'h0000;
         blocks_r <= 16'h0000;
         len_err_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (enter)
         begin
            pstate_r <= fwu_pkg::PS_SEQ;
            hdr_ok_r <= 1'b0;
            sum_r <= 16'h0000;
            blocks_r <= 16'h0000;
            len_err_r <= 1'b0;
         end
         else if (blk_take)
         begin
            unique case (pstate_r)
               fwu_pkg::PS_SEQ:
               begin
                  seq_r <= blk_byte_i;
                  pay_cnt_r <= 16'h0000;
                  if (!blk_last_i)
                     pstate_r <= fwu_pkg::PS_PAY;
               end
               fwu_pkg::PS_PAY:
               begin
                  pay_cnt_r <= pay_len;
                  sum_r <= sum_nxt;
                  if (blk_last_i)
                     pstate_r <= fwu_pkg::PS_SEQ;
                  if (hdr_end & ~compat_bad)
                  begin
                     hdr_ok_r <= 1'b1;
                     bsize_r <= {hdr_r[fwu_pkg::HDR_BSIZE_HI], hdr_r[fwu_pkg::HDR_BSIZE_LO]};
                  end
                  if (data_end)
                     blocks_r <= blocks_r + 16'h0001;
                  if (len_bad)
                     len_err_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // header bytes are kept whole; only a few are read, but the
   // array keeps the capture free of a per-byte decoder
   always_ff @(posedge ref_clk_i)
   begin
      if (clk_en_i && in_pay && accept && is_hdr && pay_cnt_r < fwu_pkg::HDR_LEN)
         hdr_r[pay_cnt_r[4:0]] <= blk_byte_i;
   end

   // -------------------------------------------------------------
   // two-entry memory write buffer
   // -------------------------------------------------------------
   // words already buffered at a restart still drain; the memory
   // side sees them before the first word of the new transfer
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_r <= 2'h0;
         ready_r <= 1'b1;
         mem_valid_r <= 1'b0;
         ent_r[0] <= '0;
         ent_r[1] <= '0;
      end
      else if (clk_en_i)
      begin
         cnt_r <= cnt_nxt;
         ready_r <= cnt_nxt < fwu_pkg::BUF_DEPTH;
         mem_valid_r <= cnt_nxt != 2'h0;
         if (pop)
         begin
            ent_r[0] <= (push && cnt_r == 2'h1) ? new_word : ent_r[1];
            if (push && cnt_r == fwu_pkg::BUF_DEPTH)
               ent_r[1] <= new_word;
         end
         else if (push)
         begin
            if (cnt_r == 2'h0)
               ent_r[0] <= new_word;
            else
               ent_r[1] <= new_word;
         end
      end
   end

   // -------------------------------------------------------------
   // responses and indicators
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rsp_valid_r <= 1'b0;
         rsp_r <= '0;
         standby_r <= 1'b0;
         led_r <= 1'b1;
         led_cnt_r <= 32'h00000000;
      end
      else if (clk_en_i)
      begin
         rsp_valid_r <= rd_req;
         if (rd_req)
            rsp_r <= '{data: rd_data, len: rd_len};
         standby_r <= upload_r & CAP_STANDBY_ONLY;
         if (!upload_r)
         begin
            led_r <= 1'b1;
            led_cnt_r <= 32'h00000000;
         end
         else if (led_cnt_r == 32'(LED_HALF_CYC - 1))
         begin
            led_r <= ~led_r;
            led_cnt_r <= 32'h00000000;
         end
         else
            led_cnt_r <= led_cnt_r + 32'h00000001;
      end
   end

   assign blk_ready_o = ready_r;
   assign rsp_valid_o = rsp_valid_r;
   assign rsp_o = rsp_r;
   assign mem_valid_o = mem_valid_r;
   assign mem_word_o = ent_r[0];
   assign upload_mode_o = upload_r;
   assign standby_req_o = standby_r;
   assign safe_mode_o = corrupt_r & ~CORRUPT_FULL_FEATURE;
   assign led_green_o = led_r;
endmodule : fwu_upload_ctrl

// *** testbench/fwu_upload_ctrl_monitor.sv ***
// concurrent checks on the ports of the firmware upload command block
`timescale 1ns/10ps
module fwu_monitor #(
   parameter logic [7:0] HW_COMPAT_FIRST = 8'h41,
   parameter logic [7:0] HW_COMPAT_SECOND = 8'h30,
   parameter logic CAP_STANDBY_ONLY = 1'b0,
   parameter logic CAP_ON_CYCLE = 1'b0,
   parameter logic CAP_ON_NOCYCLE = 1'b1,
   parameter int LED_HALF_CYC = fwu_pkg::LED_HALF_CYC
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire logic [7:0] req_code_i,
   input wire logic [7:0] req_wdata_i,
   input wire logic rsp_valid_o,
   input wire fwu_pkg::fwu_rsp_t rsp_o,
   input wire logic mem_valid_o,
   input wire fwu_pkg::fwu_mem_word_t mem_word_o,
   input wire logic mem_ready_i,
   input wire logic upload_mode_o,
   input wire logic standby_req_o,
   input wire logic safe_mode_o,
   input wire logic led_green_o
);
   // ----------------------------------------------------------
   // request decode and sequences
   // ----------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic rd_go = req_valid_i && clk_en_i && !req_write_i;
   wire logic mode_wr = req_valid_i && clk_en_i && req_write_i && req_code_i == fwu_pkg::CMD_MODE;
   sequence s_rd(logic [7:0] code);
      rd_go && req_code_i == code;
   endsequence
   sequence s_idle3;
      !upload_mode_o [*3];
   endsequence
   // run of steady led cycles in upload; a counter, as the half period can be millions of cycles
   int led_run;
   always_ff @(posedge ref_clk_i)
      led_run <= (upload_mode_o && clk_en_i && $stable(led_green_o)) ? led_run + 1 : 0;
   a_rsp_pulse: assert property ($past(clk_en_i) |-> rsp_valid_o == $past(rd_go))
      else $error("read answer not one cycle after request");
   a_compat_word: assert property (s_rd(fwu_pkg::CMD_HW_COMPAT) |=>
      rsp_o == {8'h00, HW_COMPAT_SECOND, HW_COMPAT_FIRST, 2'h2}) else $error("compat word wrong");
   a_cap_byte: assert property (s_rd(fwu_pkg::CMD_CAPABILITY) |=>
      rsp_o == {21'h0, CAP_ON_NOCYCLE, CAP_ON_CYCLE, CAP_STANDBY_ONLY, 2'h1}) else $error("capability wrong");
   a_status_rsvd: assert property (s_rd(fwu_pkg::CMD_STATUS) |=>
      rsp_o.data[23:5] == 19'h0 && rsp_o.len == 2'h2) else $error("status reserved bits or length");
   a_rev_len: assert property (s_rd(fwu_pkg::CMD_FW_REV) |=> rsp_o.len == 2'h3)
      else $error("revision length not three");
   a_mode_enter: assert property (mode_wr && req_wdata_i[0] |=> upload_mode_o)
      else $error("mode write did not enter upload");
   a_exit_refused: assert property (mode_wr && !req_wdata_i[0] && safe_mode_o |=> upload_mode_o)
      else $error("left upload with corrupt image");
   a_safe_upload: assert property (safe_mode_o |-> upload_mode_o)
      else $error("safe mode outside upload");
   a_mem_hold: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_word_o))
      else $error("memory word dropped while stalled");
   a_led_idle: assert property (s_idle3 |-> led_green_o)
      else $error("green led not steady outside upload");
   a_led_blink: assert property (led_run <= LED_HALF_CYC)
      else $error("green led not blinking in upload");
   a_standby_req: assert property (upload_mode_o == $past(upload_mode_o) |->
      standby_req_o == (upload_mode_o && CAP_STANDBY_ONLY)) else $error("standby request wrong");
endmodule : fwu_monitor
bind fwu_upload_ctrl fwu_monitor #(.HW_COMPAT_FIRST(HW_COMPAT_FIRST), .HW_COMPAT_SECOND(HW_COMPAT_SECOND),
   .CAP_STANDBY_ONLY(CAP_STANDBY_ONLY), .CAP_ON_CYCLE(CAP_ON_CYCLE), .CAP_ON_NOCYCLE(CAP_ON_NOCYCLE),
   .LED_HALF_CYC(LED_HALF_CYC)) u_mon (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
   .req_write_i(req_write_i), .req_code_i(req_code_i), .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
   .rsp_o(rsp_o), .mem_valid_o(mem_valid_o), .mem_word_o(mem_word_o), .mem_ready_i(mem_ready_i),
   .upload_mode_o(upload_mode_o), .standby_req_o(standby_req_o), .safe_mode_o(safe_mode_o),
   .led_green_o(led_green_o));

// *** testbench/fwu_mem_model.sv ***
// program memory model behind the upload block's write port
`timescale 1ns/10ps
module fwu_mem_model (
   input wire logic ref_clk_i,
   input wire logic slow_i,
   input wire logic mem_valid_i,
   input wire fwu_pkg::fwu_mem_word_t mem_word_i,
   output logic mem_ready_o
);
   // ----------------------------------------------------------
   // storage, slow mode takes one word in four cycles
   // ----------------------------------------------------------
   logic [7:0] mem [0:255];
   int wr_count = 0;
   logic [1:0] phase_r = 2'h0;
   logic ready_r = 1'b1;
   assign mem_ready_o = ready_r;
   always @(posedge ref_clk_i)
   begin
      if (mem_valid_i && mem_ready_o)
      begin
         mem[mem_word_i.addr[7:0]] <= mem_word_i.data;
         wr_count <= wr_count + 1;
      end
      phase_r <= phase_r + 2'h1;
      ready_r <= #1 !slow_i || (phase_r == 2'h3);
   end
endmodule : fwu_mem_model

// *** testbench/tb.sv ***
// self-checking bench for the firmware upload command block
`timescale 1ns/10ps
module tb;
   // ----------------------------------------------------------
   // signals and tasks
   // ----------------------------------------------------------
   localparam logic [15:0] GOOD_CRC = 16'h00d4; // byte sum of both data blocks
   logic ref_clk_i, reset_n_i, req_valid_i, req_write_i, blk_valid_i, blk_last_i, blk_ready_o;
   logic rsp_valid_o, mem_valid_o, mem_ready_i, upload_mode_o, standby_req_o, safe_mode_o, led_green_o, slow;
   logic clk_en;
   logic [7:0] req_code_i, req_wdata_i, blk_byte_i;
   logic [7:0] hdr [0:31];
   logic [7:0] q [$];
   fwu_pkg::fwu_rsp_t rsp_o;
   fwu_pkg::fwu_mem_word_t mem_word_o;
   int fail_count = 0, check_count = 0, cyc_n = 0;
   fwu_upload_ctrl #(.IMG_BLOCKS(16'h0002), .LED_HALF_CYC(4)) u_dut (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .clk_en_i(clk_en), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_code_i(req_code_i), .req_wdata_i(req_wdata_i), .blk_valid_i(blk_valid_i), .blk_byte_i(blk_byte_i),
      .blk_last_i(blk_last_i), .blk_ready_o(blk_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
      .mem_valid_o(mem_valid_o), .mem_word_o(mem_word_o), .mem_ready_i(mem_ready_i),
      .upload_mode_o(upload_mode_o), .standby_req_o(standby_req_o), .safe_mode_o(safe_mode_o),
      .led_green_o(led_green_o));
   fwu_mem_model u_mem (.ref_clk_i(ref_clk_i), .slow_i(slow), .mem_valid_i(mem_valid_o),
      .mem_word_i(mem_word_o), .mem_ready_o(mem_ready_i));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc
   task automatic chk(input logic [26:0] got, input logic [26:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic req(input logic wr, input logic [7:0] code, input logic [7:0] wd);
      req_valid_i = 1'b1;
      req_write_i = wr;
      req_code_i = code;
      req_wdata_i = wd;
      cyc(1);
      req_valid_i = 1'b0;
   endtask : req
   task automatic rd(input logic [7:0] code, input logic [25:0] exp);
      req(1'b0, code, 8'h00);
      chk({rsp_valid_o, rsp_o}, {1'b1, exp}, "read answer");
      cyc(1);
   endtask : rd
   task automatic wr(input logic [7:0] wd, input logic exp_mode);
      req(1'b1, fwu_pkg::CMD_MODE, wd);
      cyc(2);
      chk(27'(upload_mode_o), 27'(exp_mode), "upload mode");
   endtask : wr
   task automatic blk(input logic [7:0] seq, input int n, input logic [7:0] base);
      q = {seq};
      for (int i = 0; i < n; i++)
         q.push_back(seq == 8'h00 ? hdr[i] : base + 8'(i));
      foreach (q[i])
      begin
         blk_valid_i = 1'b1;
         blk_byte_i = q[i];
         blk_last_i = (i == q.size() - 1);
         // ready is registered, so its settled value decides the coming edge
         while (blk_ready_o !== 1'b1)
            cyc(1);
         cyc(1);
      end
      blk_valid_i = 1'b0;
      cyc(1);
   endtask : blk
   task automatic img(input logic [15:0] crc, input logic [7:0] first, input int nb);
      hdr = '{default: 8'h00};
      hdr[fwu_pkg::HDR_CRC_LO] = crc[7:0];
      hdr[fwu_pkg::HDR_CRC_HI] = crc[15:8];
      hdr[fwu_pkg::HDR_MAJOR] = 8'h85;
      hdr[fwu_pkg::HDR_MINOR_PRI] = 8'h02;
      hdr[fwu_pkg::HDR_MINOR_SEC] = 8'h03;
      hdr[fwu_pkg::HDR_COMPAT_1] = first;
      hdr[fwu_pkg::HDR_COMPAT_2] = 8'h30;
      hdr[fwu_pkg::HDR_BSIZE_LO] = 8'h04;
      blk(8'h00, 32, 8'h00);
      for (int k = 1; k <= nb; k++)
         blk(8'(k), 4, 8'(16 * k + 1));
      cyc(12);
   endtask : img
   // ----------------------------------------------------------
   // clock, watchdog and test sequence
   // ----------------------------------------------------------
   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i)
   begin
      cyc_n++;
      if (cyc_n == 8000)
      begin
         fail_count++;
         $display("FAIL %0t run did not finish", $time);
         report_and_stop();
      end
   end
   initial
   begin
      {reset_n_i, req_valid_i, req_write_i, blk_valid_i, blk_last_i, slow} = 6'h0;
      {req_code_i, req_wdata_i, blk_byte_i} = 24'h0;
      clk_en = 1'b1;
      cyc(10);
      reset_n_i = 1'b1;
      rd(fwu_pkg::CMD_HW_COMPAT, {24'h003041, 2'h2});
      rd(fwu_pkg::CMD_CAPABILITY, {24'h000004, 2'h1});
      rd(fwu_pkg::CMD_FW_REV, {24'h010000, 2'h3});
      rd(fwu_pkg::CMD_BLOCK, 26'h0);
      rd(fwu_pkg::CMD_STATUS, {24'h0, 2'h2});
      blk(8'h01, 4, 8'h11);
      chk(27'(u_mem.wr_count), 27'h0, "block outside upload");
      clk_en = 1'b0;
      req(1'b1, fwu_pkg::CMD_MODE, 8'h01);
      cyc(1);
      req(1'b0, fwu_pkg::CMD_STATUS, 8'h00);
      chk(27'({rsp_valid_o, upload_mode_o}), 27'h0, "clock enable low did not freeze");
      clk_en = 1'b1;
      cyc(1);
      $display("test idle done");
      wr(8'hfe, 1'b0);
      wr(8'hff, 1'b1);
      rd(fwu_pkg::CMD_MODE, {24'h000001, 2'h1});
      rd(fwu_pkg::CMD_STATUS, {24'h000002, 2'h2});
      img(GOOD_CRC, 8'h42, 2);
      rd(fwu_pkg::CMD_STATUS, {24'h000010, 2'h2});
      chk(27'(u_mem.wr_count), 27'h0, "refused image written");
      $display("test refuse done");
      wr(8'h01, 1'b1);
      slow = 1'b1;
      img(GOOD_CRC, 8'h41, 1);
      wr(8'h01, 1'b1);
      rd(fwu_pkg::CMD_STATUS, {24'h000002, 2'h2});
      img(GOOD_CRC, 8'h41, 2);
      slow = 1'b0;
      rd(fwu_pkg::CMD_STATUS, {24'h000001, 2'h2});
      for (int a = 0; a < 8; a++)
         chk(27'(u_mem.mem[a]), 27'(a < 4 ? 8'h11 + a : 8'h1d + a), "program memory");
      rd(fwu_pkg::CMD_FW_REV, {24'h850203, 2'h3});
      chk(27'(safe_mode_o), 27'h0, "safe mode after good image");
      wr(8'h00, 1'b0);
      $display("test restart done");
      wr(8'h01, 1'b1);
      img(16'h1234, 8'h41, 2);
      rd(fwu_pkg::CMD_STATUS, {24'h000004, 2'h2});
      chk(27'(safe_mode_o), 27'h1, "safe mode after bad image");
      wr(8'h00, 1'b1);
      wr(8'h01, 1'b1);
      rd(fwu_pkg::CMD_STATUS, {24'h000002, 2'h2});
      img(GOOD_CRC, 8'h41, 2);
      rd(fwu_pkg::CMD_STATUS, {24'h000001, 2'h2});
      wr(8'h00, 1'b0);
      $display("test corrupt done");
      report_and_stop();
   end
endmodule : tb
